// ### rtl/dgpc_pkg.sv
// Constants for the dual pin configuration block
package dgpc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] DGPC_EXT_PREFIX  = 4'hf;
  localparam logic [3:0] DGPC_WR_CFG_A    = 4'h0;
  localparam logic [3:0] DGPC_WR_CFG_B    = 4'h1;
  localparam logic [3:0] DGPC_WR_DATA     = 4'h2;
  localparam logic [4:0] DGPC_RD_CFG_A    = 5'h1b;
  localparam logic [4:0] DGPC_RD_CFG_B    = 5'h1c;
  localparam logic [4:0] DGPC_RD_DATA     = 5'h1d;
  localparam logic [7:0] DGPC_RESET_VALUE = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DGPC_TWO_IRQ_EN  = 0;
  localparam int DGPC_TWO_DIR     = 1;
  localparam int DGPC_TWO_POL     = 2;
  localparam int DGPC_TWO_FUNC    = 3;
  localparam int DGPC_ONE_IRQ_EN  = 4;
  localparam int DGPC_ONE_DIR     = 5;
  localparam int DGPC_ONE_POL     = 6;
  localparam int DGPC_ONE_FUNC    = 7;
  localparam int DGPC_ONE_LEVEL   = 7;
  localparam int DGPC_TWO_LEVEL   = 6;
  localparam int DGPC_LEVEL_MASK  = 8'hc0;
endpackage

// ### rtl/dgpc_top.sv
// Dual pin configuration registers, pin drivers and shared interrupt
`timescale 1ns/1ps
`default_nettype none
module dgpc_top
  import dgpc_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       wr_strobe_in,
  input  wire logic [15:0] wr_word_in,
  input  wire logic [4:0] rd_addr_in,
  output logic      [7:0] rd_data_out,
  input  wire logic       pin_one_in,
  output logic            pin_one_out,
  output logic            pin_one_oe_out,
  input  wire logic       pin_two_in,
  output logic            pin_two_out,
  output logic            pin_two_oe_out,
  output logic            analog_input_one_sel_out,
  output logic            analog_input_two_sel_out,
  output logic            irq_out
);
  import dgpc_pkg::*;

  // ----------------------------------------
  // Registers and pin synchronisers
  // ----------------------------------------
  logic [7:0] cfg_a_q;
  logic [7:0] cfg_b_q;
  logic [7:0] data_q;
  logic [2:0] one_sync_q;
  logic [2:0] two_sync_q;
  logic       one_lvl_q;
  logic       two_lvl_q;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Extended map prefix
  wire ext_sel   = wr_strobe_in && (wr_word_in[15:12] == DGPC_EXT_PREFIX);
  wire wr_cfg_a  = ext_sel && (wr_word_in[11:8] == DGPC_WR_CFG_A);
  wire wr_cfg_b  = ext_sel && (wr_word_in[11:8] == DGPC_WR_CFG_B);
  wire wr_data   = ext_sel && (wr_word_in[11:8] == DGPC_WR_DATA);
  wire [7:0] wr_byte = wr_word_in[7:0];

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  // Pin one role
  wire pin_one_function_select = cfg_a_q[DGPC_ONE_FUNC];
  wire pin_two_function_select = cfg_a_q[DGPC_TWO_FUNC];
  wire pin_one_direction       = cfg_a_q[DGPC_ONE_DIR];
  wire pin_two_direction       = cfg_a_q[DGPC_TWO_DIR];
  wire pin_one_polarity        = cfg_a_q[DGPC_ONE_POL];
  wire pin_two_polarity        = cfg_a_q[DGPC_TWO_POL];
  wire pin_one_irq_enable      = cfg_a_q[DGPC_ONE_IRQ_EN];
  wire pin_two_irq_enable      = cfg_a_q[DGPC_TWO_IRQ_EN];

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Driver off in analog mode
  assign pin_one_oe_out = pin_one_function_select && !pin_one_direction;
  assign pin_two_oe_out = pin_two_function_select && !pin_two_direction;
  assign pin_one_out    = data_q[DGPC_ONE_LEVEL];
  assign pin_two_out    = data_q[DGPC_TWO_LEVEL];
  assign analog_input_one_sel_out = !pin_one_function_select;
  assign analog_input_two_sel_out = !pin_two_function_select;

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // Active level raises interrupt
  wire one_active = pin_one_function_select && pin_one_direction && pin_one_irq_enable
                    && (one_lvl_q == pin_one_polarity);
  wire two_active = pin_two_function_select && pin_two_direction && pin_two_irq_enable
                    && (two_lvl_q == pin_two_polarity);
  assign irq_out = one_active || two_active;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Input pins report their level
  wire one_rd = pin_one_direction ? one_lvl_q : data_q[DGPC_ONE_LEVEL];
  wire two_rd = pin_two_direction ? two_lvl_q : data_q[DGPC_TWO_LEVEL];
  wire [7:0] data_rd = {one_rd, two_rd, 6'h00};
  wire [7:0] rd_mux = (rd_addr_in == DGPC_RD_CFG_A) ? cfg_a_q :
                      (rd_addr_in == DGPC_RD_CFG_B) ? cfg_b_q :
                      (rd_addr_in == DGPC_RD_DATA)  ? data_rd : 8'h00;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Reset to zero, write on decode
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cfg_a_q     <= DGPC_RESET_VALUE;
      cfg_b_q     <= DGPC_RESET_VALUE;
      data_q      <= DGPC_RESET_VALUE;
      rd_data_out <= 8'h00;
    end
    else
    begin
      if (wr_cfg_a)
        cfg_a_q <= wr_byte;
      if (wr_cfg_b)
        cfg_b_q <= wr_byte;
      if (wr_data)
        data_q <= wr_byte & DGPC_LEVEL_MASK[7:0];
      rd_data_out <= rd_mux;
    end
  end

  // Pin input synchronisers
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      one_sync_q <= 3'h0;
      two_sync_q <= 3'h0;
      one_lvl_q  <= 1'b0;
      two_lvl_q  <= 1'b0;
    end
    else
    begin
      one_sync_q <= {one_sync_q[1:0], pin_one_in};
      two_sync_q <= {two_sync_q[1:0], pin_two_in};
      if (one_sync_q[2] == one_sync_q[1])
        one_lvl_q <= one_sync_q[2];
      if (two_sync_q[2] == two_sync_q[1])
        two_lvl_q <= two_sync_q[2];
    end
  end
endmodule
`default_nettype wire

// ### verification/dgpc_checker.sv
// Assertion checker for the dual pin block
`timescale 1ns/1ps
`default_nettype none
module dgpc_checker (
  input wire logic        ref_clk_in, reset_in, wr_strobe_in, pin_one_in, pin_two_in,
  input wire logic        pin_one_oe_out, pin_two_oe_out, irq_out,
  input wire logic        analog_input_one_sel_out, analog_input_two_sel_out,
  input wire logic [15:0] wr_word_in,
  input wire logic [4:0]  rd_addr_in,
  input wire logic [7:0]  rd_data_out
);
  logic [7:0] a_q;
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in) a_q <= 8'h00;
    else if (wr_strobe_in && wr_word_in[15:8] == 8'hf0) a_q <= wr_word_in[7:0];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  property p_oe1; pin_one_oe_out == (a_q[7] && !a_q[5]); endproperty
  a_oe1: assert property (p_oe1) else $error("pin one enable");
  property p_oe2; pin_two_oe_out == (a_q[3] && !a_q[1]); endproperty
  a_oe2: assert property (p_oe2) else $error("pin two enable");
  property p_an;
    {analog_input_one_sel_out, analog_input_two_sel_out} == ~{a_q[7], a_q[3]}; endproperty
  a_an: assert property (p_an) else $error("analog select");
  property p_rd; rd_addr_in == 5'h1b |=> rd_data_out == $past(a_q); endproperty
  a_rd: assert property (p_rd) else $error("readback");
  property p_mask; !a_q[0] && !a_q[4] |-> !irq_out; endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_hi1; (a_q == 8'hf0 && pin_one_in) [*6] |-> irq_out; endproperty
  a_hi1: assert property (p_hi1) else $error("pin one irq");
  property p_lo1; (a_q == 8'hf0 && !pin_one_in) [*6] |-> !irq_out; endproperty
  a_lo1: assert property (p_lo1) else $error("pin one idle");
  property p_lo2; (a_q == 8'h0b && !pin_two_in) [*6] |-> irq_out; endproperty
  a_lo2: assert property (p_lo2) else $error("pin two irq");
endmodule
`default_nettype wire

// ### verification/dgpc_host.sv
// Host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module dgpc_host (
  input  wire logic        clk_in,
  input  wire logic [7:0]  rd_data_in,
  output logic             stb_out,
  output logic      [15:0] word_out,
  output logic      [4:0]  ra_out
);
  initial {stb_out, word_out, ra_out} = '0;
  task automatic wr(input logic [15:0] w);
    @(negedge clk_in);
    stb_out = 1;
    word_out = w;
    @(negedge clk_in);
    stb_out = 0;
    word_out = ~w;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_in);
    ra_out = a;
    @(negedge clk_in);
    d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// ### verification/tb_dual_gpio_pin_configuration.sv
// Self-checking bench for the dual pin block
`timescale 1ns/1ps
`default_nettype none
bind dgpc_top dgpc_checker chk_i (.*);
module tb_dual_gpio_pin_configuration;
  logic        ref_clk_in = 0, reset_in = 1, stb, p1 = 0, p2 = 0, o1, e1, o2, e2, s1, s2, irq;
  logic [15:0] word;
  logic [4:0]  ra;
  logic [7:0]  rd, got, tbl [8] = '{8'hf0, 8'hb0, 8'h0f, 8'h0b, 8'he0, 8'h0e, 8'hff, 8'h50};
  int          num_errors = 0, comparisons = 0, seed = 47, a, b;
  always #20 ref_clk_in = ~ref_clk_in;
  dgpc_host hst (.clk_in(ref_clk_in), .rd_data_in(rd), .stb_out(stb), .word_out(word),
    .ra_out(ra));
  dgpc_top uut (.ref_clk_in, .reset_in, .wr_strobe_in(stb), .wr_word_in(word), .rd_addr_in(ra),
    .rd_data_out(rd), .pin_one_in(p1), .pin_one_out(o1), .pin_one_oe_out(e1), .pin_two_in(p2),
    .pin_two_out(o2), .pin_two_oe_out(e2), .analog_input_one_sel_out(s1),
    .analog_input_two_sel_out(s2), .irq_out(irq));
  function automatic logic [7:0] exp_pins(int c, logic q1, logic q2);
    return {3'h0, c[7] & !c[5], c[3] & !c[1], !c[7], !c[3],
      c[7] & c[5] & c[4] & (q1 == c[6]) | c[3] & c[1] & c[0] & (q2 == c[2])};
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task rdk(input logic [4:0] x, input int e);
    hst.rd(x, got);
    chk(got, e[7:0]);
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge ref_clk_in);
    reset_in = 0;
    rdk(5'h1b, 0);
    rdk(5'h1c, 0);
    chk({e1, e2, s1, s2}, 8'h3);
    for (int i = 0; i < 32; i++)
    begin
      a = i < 16 ? tbl[i >> 1] : $random(seed);
      b = $random(seed);
      {p1, p2} = {2{i[0]}};
      hst.wr({4'hf, 4'h0, a[7:0]});
      hst.wr({4'he, 4'h0, ~a[7:0]});
      hst.wr({4'hf, 4'h1, b[7:0]});
      repeat (8) @(negedge ref_clk_in);
      chk({3'h0, e1, e2, s1, s2, irq}, exp_pins(a, p1, p2));
      rdk(5'h1b, a);
      rdk(5'h1c, b);
    end
    hst.wr({4'hf, 4'h2, 8'h80});
    chk({o1, o2}, 8'h2);
    hst.wr({4'hf, 4'h0, 8'h00});
    rdk(5'h1d, 8'h80);
    {p1, p2} = 2'b01;
    hst.wr({4'hf, 4'h0, 8'h22});
    repeat (8) @(negedge ref_clk_in);
    rdk(5'h1d, 8'h40);
    rdk(5'h00, 0);
    reset_in = 1;
    repeat (2) @(negedge ref_clk_in);
    reset_in = 0;
    rdk(5'h1b, 0);
    chk({o1, o2, e1, e2, s1, s2, irq}, 8'h6);
    conclude;
  end
  initial
  begin
    #100us;
    num_errors++;
    conclude;
  end
endmodule
`default_nettype wire
